// ==== src/itra_pkg.sv ====
// Function
// - Each received byte is acknowledged by pulling data low on the ninth clock, except an unmatched address or a general-call byte other than 0x06.
// - Second byte of a write frame is the command selecting the register.
// - Register value travels high byte (bits 15..8) first, then low byte.
// - Received value is committed at the falling clock edge ending the low-byte ack.
// - On stop the target releases the bus and idles until a new start.
// - First byte after a start is the address, direction bit in its lsb.
// - Besides broadcast and general call, only addresses with the fixed prefix in the upper four bits and the strap code below it are answered.
// - Strap pin is sampled during the first byte of every frame and latched.
// - Strap decode: ground 000, supply 001, data line 010, clock line 011.
// - Broadcast address 1000111 with write direction is acknowledged regardless of strap.
// - Broadcast address is for writes only; broadcast reads are not acknowledged.
// - In the read phase the target sends high byte, then low byte.
// - General call 0x00 then 0x06 fires a software reset at the second ack.
// - Only seven-bit addressing; ten-bit frames are not acknowledged.
package itra_pkg;
  localparam logic [3:0] ADDR_PREFIX    = 4'h9;
  localparam logic [6:0] BCAST_ADDR     = 7'h47;
  localparam logic [6:0] GCALL_ADDR     = 7'h00;
  localparam logic [7:0] GCALL_RESET    = 8'h06;
  localparam logic [2:0] STRAP_GND      = 3'h0;
  localparam logic [2:0] STRAP_VDD      = 3'h1;
  localparam logic [2:0] STRAP_SDA      = 3'h2;
  localparam logic [2:0] STRAP_SCL      = 3'h3;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [1:0] BYTE_ADDR      = 2'h0;
  localparam logic [1:0] BYTE_CMD       = 2'h1;
  localparam logic [1:0] BYTE_HIGH      = 2'h2;
  localparam logic [1:0] BYTE_LOW       = 2'h3;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;
  typedef enum logic [2:0] {
    ITRA_IDLE  = 3'b000,
    ITRA_RECV  = 3'b001,
    ITRA_RACK  = 3'b010,
    ITRA_SEND  = 3'b011,
    ITRA_TACK  = 3'b100
  } itra_state_e;
endpackage

// ==== src/itra_target.sv ====
module itra_target
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Strap pin levels, already resolved to a source
  input  wire logic        strap_vdd,
  input  wire logic        strap_sda,
  input  wire logic        strap_scl,
  // Register side
  output logic [7:0]       reg_sel,
  output logic [15:0]      reg_wdata,
  output logic             reg_we,
  output logic             reg_bcast,
  input  wire logic [15:0] reg_rdata,
  output logic             sw_reset
);
  logic [1:0]  scl_sync_ff;
  logic [1:0]  sda_sync_ff;
  logic [2:0]  strap_sync0_ff;
  logic [2:0]  strap_sync1_ff;
  logic        scl_d_ff;
  logic        sda_d_ff;
  itra_pkg::itra_state_e state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [1:0]  byte_idx_ff;
  logic [7:0]  shift_ff;
  logic        rd_ff;
  logic        bcast_ff;
  logic        gcall_ff;
  logic        hi_sent_ff;
  logic [7:0]  hi_ff;
  logic [2:0]  strap_ff;
  logic [15:0] tx_ff;
  logic        nack_pend_ff;
  logic        commit_pend_ff;
  logic        reset_pend_ff;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] rx_byte;
  logic       addr_match;
  logic       addr_ok;

  assign scl      = scl_sync_ff[1];
  assign sda      = sda_sync_ff[1];
  assign scl_rise = scl & ~scl_d_ff;
  assign scl_fall = ~scl & scl_d_ff;
  assign start_det = scl & scl_d_ff & sda_d_ff & ~sda;
  assign stop_det  = scl & scl_d_ff & ~sda_d_ff & sda;
  assign rx_byte  = {shift_ff[6:0], sda};
  // Address check on the stored byte at the ack edge; strap latched while it shifted in
  // A ten-bit prefix never equals the fixed prefix, so such frames go unanswered
  assign addr_match = shift_ff[7:4] == itra_pkg::ADDR_PREFIX
                      && shift_ff[3:1] == strap_ff;
  assign addr_ok    = addr_match
                      || (shift_ff[7:1] == itra_pkg::BCAST_ADDR && !shift_ff[0])
                      || (shift_ff[7:1] == itra_pkg::GCALL_ADDR && !shift_ff[0]);

  // Two-flop synchronisers; first stage read only by the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_ff    <= 2'h3;
      sda_sync_ff    <= 2'h3;
      strap_sync0_ff <= 3'h0;
      strap_sync1_ff <= 3'h0;
      scl_d_ff       <= 1'b1;
      sda_d_ff       <= 1'b1;
    end
    else
    begin
      scl_sync_ff    <= {scl_sync_ff[0], scl_i};
      sda_sync_ff    <= {sda_sync_ff[0], sda_i};
      strap_sync0_ff <= {strap_vdd, strap_sda, strap_scl};
      strap_sync1_ff <= strap_sync0_ff;
      scl_d_ff       <= scl;
      sda_d_ff       <= sda;
    end
  end

  // Strap decode, refreshed during each first byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      strap_ff <= itra_pkg::STRAP_GND;
    else if (state_ff == itra_pkg::ITRA_RECV && byte_idx_ff == itra_pkg::BYTE_ADDR
             && scl_rise)
    begin
      if (strap_sync1_ff[2])
        strap_ff <= itra_pkg::STRAP_VDD;
      else if (strap_sync1_ff[1])
        strap_ff <= itra_pkg::STRAP_SDA;
      else if (strap_sync1_ff[0])
        strap_ff <= itra_pkg::STRAP_SCL;
      else
        strap_ff <= itra_pkg::STRAP_GND;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff       <= itra_pkg::ITRA_IDLE;
      bit_cnt_ff     <= 4'h0;
      byte_idx_ff    <= itra_pkg::BYTE_ADDR;
      shift_ff       <= 8'h00;
      rd_ff          <= 1'b0;
      bcast_ff       <= 1'b0;
      gcall_ff       <= 1'b0;
      hi_sent_ff     <= 1'b0;
      hi_ff          <= 8'h00;
      reg_sel        <= 8'h00;
      tx_ff          <= itra_pkg::RDATA_RESET;
      sda_o          <= 1'b0;
      sda_oe         <= 1'b0;
      nack_pend_ff   <= 1'b0;
      commit_pend_ff <= 1'b0;
      reset_pend_ff  <= 1'b0;
      reg_wdata      <= 16'h0000;
      reg_we         <= 1'b0;
      reg_bcast      <= 1'b0;
      sw_reset       <= 1'b0;
    end
    else
    begin
      reg_we   <= 1'b0;
      sw_reset <= 1'b0;
      if (start_det)
      begin
        // Start or repeated start: next byte is an address
        state_ff    <= itra_pkg::ITRA_RECV;
        bit_cnt_ff  <= 4'h0;
        byte_idx_ff <= itra_pkg::BYTE_ADDR;
        sda_oe      <= 1'b0;
        commit_pend_ff <= 1'b0;
        reset_pend_ff  <= 1'b0;
      end
      else if (stop_det)
      begin
        state_ff <= itra_pkg::ITRA_IDLE;
        sda_oe   <= 1'b0;
        commit_pend_ff <= 1'b0;
        reset_pend_ff  <= 1'b0;
      end
      else
      begin
        unique case (state_ff)
          itra_pkg::ITRA_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          itra_pkg::ITRA_RECV:
          begin
            if (scl_rise)
            begin
              shift_ff   <= rx_byte;
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (scl_fall && bit_cnt_ff == itra_pkg::BIT_ACK)
            begin
              nack_pend_ff <= 1'b1;
              state_ff     <= itra_pkg::ITRA_RACK;
              sda_oe       <= 1'b0;
              if (byte_idx_ff == itra_pkg::BYTE_ADDR)
              begin
                if (addr_ok)
                begin
                  sda_oe   <= 1'b1;
                  nack_pend_ff <= 1'b0;
                  rd_ff    <= shift_ff[0];
                  bcast_ff <= shift_ff[7:1] == itra_pkg::BCAST_ADDR;
                  gcall_ff <= shift_ff[7:1] == itra_pkg::GCALL_ADDR;
                  tx_ff    <= reg_rdata;
                  hi_sent_ff <= 1'b0;
                end
              end
              else if (gcall_ff)
              begin
                sda_oe <= shift_ff == itra_pkg::GCALL_RESET;
                nack_pend_ff  <= shift_ff != itra_pkg::GCALL_RESET;
                reset_pend_ff <= shift_ff == itra_pkg::GCALL_RESET;
              end
              else
              begin
                sda_oe <= 1'b1;
                nack_pend_ff <= 1'b0;
                if (byte_idx_ff == itra_pkg::BYTE_CMD)
                  reg_sel <= shift_ff;
                else if (byte_idx_ff == itra_pkg::BYTE_HIGH)
                  hi_ff <= shift_ff;
                else
                  commit_pend_ff <= 1'b1;
              end
            end
          end
          itra_pkg::ITRA_RACK:
          begin
            if (scl_rise && reset_pend_ff)
            begin
              sw_reset      <= 1'b1;
              reset_pend_ff <= 1'b0;
            end
            if (scl_fall)
            begin
              sda_oe     <= 1'b0;
              bit_cnt_ff <= 4'h0;
              if (commit_pend_ff)
              begin
                reg_wdata <= {hi_ff, shift_ff};
                reg_we    <= 1'b1;
                reg_bcast <= bcast_ff;
                commit_pend_ff <= 1'b0;
              end
              if (nack_pend_ff)
                state_ff <= itra_pkg::ITRA_IDLE;
              else if (byte_idx_ff == itra_pkg::BYTE_ADDR && rd_ff)
              begin
                state_ff <= itra_pkg::ITRA_SEND;
                sda_oe   <= ~tx_ff[15];
                sda_o    <= 1'b0;
                tx_ff    <= {tx_ff[14:0], 1'b0};
                bit_cnt_ff <= 4'h1;
              end
              else
              begin
                state_ff    <= itra_pkg::ITRA_RECV;
                byte_idx_ff <= byte_idx_ff == itra_pkg::BYTE_LOW ? itra_pkg::BYTE_HIGH
                                                                 : byte_idx_ff + 2'h1;
              end
            end
          end
          itra_pkg::ITRA_SEND:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_ff == 4'h8)
              begin
                sda_oe   <= 1'b0;
                state_ff <= itra_pkg::ITRA_TACK;
              end
              else
              begin
                sda_oe     <= ~tx_ff[15];
                tx_ff      <= {tx_ff[14:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          itra_pkg::ITRA_TACK:
          begin
            if (scl_rise)
              nack_pend_ff <= sda | hi_sent_ff;
            if (scl_fall)
            begin
              if (nack_pend_ff)
                state_ff <= itra_pkg::ITRA_IDLE;
              else
              begin
                hi_sent_ff <= 1'b1;
                state_ff   <= itra_pkg::ITRA_SEND;
                sda_oe     <= ~tx_ff[15];
                tx_ff      <= {tx_ff[14:0], 1'b0};
                bit_cnt_ff <= 4'h1;
              end
            end
          end
          default:
          begin
            state_ff <= itra_pkg::ITRA_IDLE;
            sda_oe   <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // itra_target

// ==== verif/itra_target_monitor.sv ====
module itra_target_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus pins
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Register side
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_bcast,
  input wire logic        sw_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Open drain: the target may only pull low
  property p_open_drain;
    sda_oe |-> sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_ack_start;
    $rose(sda_oe) |-> !scl_i;
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("drive began with clock high");
  // A drive must hold for at least five cycles once it begins
  property p_ack_hold;
    $rose(sda_oe) |-> sda_oe [*5];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("drive released early");
  property p_high_stable;
    scl_i && $past(scl_i) |-> $stable(sda_oe);
  endproperty
  a_high_stable: assert property (p_high_stable) else $error("data moved with clock high");
  property p_commit;
    reg_we |-> !scl_i ##1 !reg_we;
  endproperty
  a_commit: assert property (p_commit) else $error("commit not on low clock pulse");
  property p_wdata_cause;
    $changed(reg_wdata) |-> reg_we;
  endproperty
  a_wdata_cause: assert property (p_wdata_cause) else $error("value moved without commit");
  property p_bcast_cause;
    $changed(reg_bcast) |-> reg_we;
  endproperty
  a_bcast_cause: assert property (p_bcast_cause) else $error("broadcast flag moved alone");
  property p_stop_idle;
    scl_i && $rose(sda_i) |-> !sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus held after stop");
  property p_swreset;
    sw_reset |-> scl_i ##1 !sw_reset;
  endproperty
  a_swreset: assert property (p_swreset) else $error("reset pulse misplaced");
  c_commit: cover property (reg_we && reg_bcast);
  c_swreset: cover property (sw_reset);
  c_ack: cover property ($rose(sda_oe));
endmodule // itra_target_monitor

bind itra_target itra_target_monitor u_mon (.clk, .rst, .scl_i, .sda_i, .sda_o, .sda_oe,
  .reg_wdata, .reg_we, .reg_bcast, .sw_reset);

// ==== verif/itra_ctl_model.sv ====
module itra_ctl_model
(
  // Clock
  input  wire logic clk,
  // Bus pins, data released when sda_drv is high
  output logic      scl = 1'b1,
  output logic      sda_drv = 1'b1,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data moves only while the clock is low; one bit takes 80 ns
  task automatic bitx(input logic b, output logic r);
    repeat (2) @(posedge clk);
    sda_drv <= b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    r = sda;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
  // Also serves as repeated start: data raised while the clock is low
  task automatic start();
    repeat (2) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule // itra_ctl_model

// ==== verif/test_i2c_target_register_access.sv ====
module test_i2c_target_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap_vdd = 1'b0, strap_sda = 1'b0, strap_scl = 1'b0;
  logic        sda_o, sda_oe, reg_we, reg_bcast, sw_reset;
  logic [7:0]  reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata = 16'h0000;
  wire logic   scl, sda, sda_drv;
  int          error_cnt, checks_done, we_cnt, swr_cnt;
  // Pull-up on the data line
  assign sda = sda_drv & ~(sda_oe & ~sda_o);
  itra_ctl_model u_ctl (.clk, .scl, .sda_drv, .sda);
  itra_target u_dut (.clk, .rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .strap_vdd,
    .strap_sda, .strap_scl, .reg_sel, .reg_wdata, .reg_we, .reg_bcast, .reg_rdata, .sw_reset);
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Stand-in register file: readback derived from the selected register
  always @(posedge clk)
  begin
    reg_rdata <= {reg_sel, ~reg_sel};
    we_cnt <= we_cnt + int'(reg_we === 1'b1);
    swr_cnt <= swr_cnt + int'(sw_reset === 1'b1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sends one byte; lvl is the expected data level in the ninth clock
  task automatic wb(input logic [7:0] d, input logic lvl);
    logic [7:0] q;
    logic       k;
    u_ctl.xfer(d, 1'b1, q, k);
    chk({15'h0000, k}, {15'h0000, lvl});
  endtask
  task automatic t_strap_write();
    logic [2:0] code [4];
    int         n;
    code = '{itra_pkg::STRAP_GND, itra_pkg::STRAP_VDD, itra_pkg::STRAP_SDA,
             itra_pkg::STRAP_SCL};
    for (int s = 0; s < 4; s++)
    begin
      strap_vdd <= (s == 1);
      strap_sda <= (s == 2);
      strap_scl <= (s == 3);
      n = we_cnt;
      u_ctl.start();
      wb({itra_pkg::ADDR_PREFIX, code[s], 1'b0}, 1'b0);
      wb(8'h10 + 8'(s), 1'b0);
      wb(8'hC3 ^ 8'(s), 1'b0);
      wb(8'h3C + 8'(s), 1'b0);
      u_ctl.stop();
      chk(16'(we_cnt - n), 16'h0001);
      chk({8'h00, reg_sel}, 16'h0010 + 16'(s));
      chk(reg_wdata, {8'hC3 ^ 8'(s), 8'h3C + 8'(s)});
      chk({15'h0000, reg_bcast}, 16'h0000);
      u_ctl.start();
      wb({itra_pkg::ADDR_PREFIX, code[(s + 1) % 4], 1'b0}, 1'b1);
      u_ctl.stop();
      chk(16'(we_cnt - n), 16'h0001);
    end
    $display("done strap_write");
  endtask
  task automatic t_bcast();
    int n;
    strap_vdd <= 1'b1;
    n = we_cnt;
    u_ctl.start();
    wb({itra_pkg::BCAST_ADDR, 1'b0}, 1'b0);
    wb(8'h21, 1'b0);
    wb(8'hA5, 1'b0);
    wb(8'h0F, 1'b0);
    wb(8'h96, 1'b0);
    wb(8'h69, 1'b0);
    u_ctl.stop();
    chk(16'(we_cnt - n), 16'h0002);
    chk(reg_wdata, 16'h9669);
    chk({15'h0000, reg_bcast}, 16'h0001);
    u_ctl.start();
    wb({itra_pkg::BCAST_ADDR, 1'b1}, 1'b1);
    u_ctl.start();
    wb(8'hF0, 1'b1);
    u_ctl.stop();
    chk(16'(we_cnt - n), 16'h0002);
    $display("done bcast");
  endtask
  task automatic t_read();
    logic [7:0] hi;
    logic [7:0] lo;
    logic       k;
    strap_vdd <= 1'b0;
    strap_scl <= 1'b1;
    u_ctl.start();
    wb({itra_pkg::ADDR_PREFIX, itra_pkg::STRAP_SCL, 1'b0}, 1'b0);
    wb(8'h5A, 1'b0);
    u_ctl.start();
    wb({itra_pkg::ADDR_PREFIX, itra_pkg::STRAP_SCL, 1'b1}, 1'b0);
    u_ctl.xfer(8'hFF, 1'b0, hi, k);
    u_ctl.xfer(8'hFF, 1'b1, lo, k);
    u_ctl.stop();
    chk({hi, lo}, 16'h5AA5);
    $display("done read");
  endtask
  task automatic t_gcall();
    int n;
    n = swr_cnt;
    u_ctl.start();
    wb(8'h00, 1'b0);
    wb(8'h07, 1'b1);
    u_ctl.stop();
    chk(16'(swr_cnt - n), 16'h0000);
    u_ctl.start();
    wb({itra_pkg::GCALL_ADDR, 1'b0}, 1'b0);
    wb(itra_pkg::GCALL_RESET, 1'b0);
    u_ctl.stop();
    chk(16'(swr_cnt - n), 16'h0001);
    $display("done gcall");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({reg_wdata[14:0], sda_oe}, 16'h0000);
    t_strap_write();
    t_bcast();
    t_read();
    t_gcall();
    summarize();
  end
  // Whole run needs about 4000 cycles; the limit leaves a wide margin
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // test_i2c_target_register_access
